// ===== rtl/lpm_wake_ctrl.sv
// low-power sleep level control with interrupt wake, stacking and return
// assumes one AHB-Lite master, an asynchronous interrupt request pin and
// clock gates downstream that obey the enables driven here
//
// How it works
// - an enabled request wakes the core from any sleep level and starts service
// - service entry pushes program counter then status word onto the stack
// - service entry clears cpu halt, submain off, crystal off; generator bit kept
// - return pops the status word from the stack, resuming the earlier level
// - a stacked status word altered in the handler takes effect on return
// - sixteen 16-bit core registers; three dedicated, thirteen general
// - setting a sleep bit changes the clock gates on the next edge
// - sleep bits decode to active, levels 0 to 4 or other, with matching clock gates
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
module lpm_wake_ctrl
   import lpm_wake_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   input  wire logic        hclk,            // bus and core clock
   input  wire logic        hresetn,         // async reset, active low
   input  wire logic        ce,              // clock enable, freezes state when low
   input  wire logic        hsel,            // slave select
   input  wire logic [31:0] haddr,           // byte address
   input  wire logic [1:0]  htrans,          // transfer type
   input  wire logic        hwrite,          // write when high
   input  wire logic [2:0]  hsize,           // transfer size, word only
   input  wire logic [31:0] hwdata,          // write data
   input  wire logic        hready,          // bus ready
   output logic             hreadyout,       // slave ready
   output logic             hresp,           // always okay
   output logic [31:0]      hrdata,          // read data
   input  wire logic        irq_pin,         // interrupt request level from pin
   output logic             irq_ack,         // one-cycle pulse on service entry
   output logic             cpu_clk_en,      // cpu and main clock gate
   output logic             submain_clk_en,  // submain_clock gate
   output logic             digital_osc_en,  // digital_osc enable
   output logic             dco_gen_en,      // digital_osc generator enable
   output logic             crystal_osc_en,  // crystal oscillator and aux clock enable
   output logic [2:0]       sleep_level      // decoded level code
);

   localparam int SIDX_W = $clog2(STACK_DEPTH);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [SIDX_W-1:0] stk_idx(input logic [15:0] sp);
      stk_idx = sp[SIDX_W:1];
   endfunction

   function automatic logic [2:0] level_of(input logic [15:0] sw);
      logic [3:0] b;
      b = {sw[SUB_OFF_POS], sw[GEN_OFF_POS], sw[XTAL_OFF_POS], sw[HALT_POS]};
      unique case (b)
         4'h0:    level_of = LVL_ACTIVE;
         4'h1:    level_of = LVL_0;
         4'h5:    level_of = LVL_1;
         4'h9:    level_of = LVL_2;
         4'hD:    level_of = LVL_3;
         4'hF:    level_of = LVL_4;
         default: level_of = LVL_OTHER;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [15:0]       core_q [NUM_CORE_REGS];
   logic [15:0]       stack_q [STACK_DEPTH];
   logic [15:0]       vector_q;
   logic              irq_en_q;
   logic              ret_rq_q;
   logic              in_service_q;
   seq_state_t        state_q;
   logic [2:0]        irq_sync_q;
   logic              irq_lvl_q;
   logic              wr_pend_q;
   logic [7:0]        wr_addr_q;
   logic [31:0]       rdata_q;
   logic              ack_q;
   logic [4:0]        gate_q;
   logic [2:0]        level_q;

   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   wire logic        addr_phase = hsel & htrans[1] & hready;
   wire logic [7:0]  rd_addr    = haddr[7:0];
   wire logic [15:0] pc_w       = core_q[PC_IDX];
   wire logic [15:0] sp_w       = core_q[SP_IDX];
   wire logic [15:0] sw_w       = core_q[SW_IDX];
   wire logic [15:0] sp_dn      = sp_w - STACK_STEP;
   wire logic [15:0] sp_up      = sp_w + STACK_STEP;
   wire logic [15:0] stk_top    = stack_q[stk_idx(sp_w)];
   wire logic        wr_core    = wr_pend_q & (wr_addr_q < CTRL_OFFSET);
   wire logic [3:0]  wr_ridx    = wr_addr_q[5:2];
   wire logic [15:0] wd16       = hwdata[15:0];
   wire logic        irq_take   = (state_q == ST_RUN) & ~wr_pend_q & irq_lvl_q & irq_en_q
                                  & sw_w[IRQ_ON_POS] & ~in_service_q;
   wire logic        ret_take   = (state_q == ST_RUN) & ~wr_pend_q & ret_rq_q & in_service_q;
   wire logic [31:0] status_w   = {24'h00_0000, in_service_q, level_of(sw_w), 1'b0, 3'(state_q)};

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = RDATA_RST;
      if (rd_addr < CTRL_OFFSET)
         rd_mux = {16'h0000, core_q[rd_addr[5:2]]};
      else if (rd_addr == STATE_OFFSET)
         rd_mux = status_w;
      else if (rd_addr == VECTOR_OFFSET)
         rd_mux = {16'h0000, vector_q};
      else if (rd_addr == STKTOP_OFFSET)
         rd_mux = {16'h0000, stk_top};
      else if (rd_addr == IRQEN_OFFSET)
         rd_mux = {31'h0000_0000, irq_en_q};
   end

   // ------------------------------------------------------------------
   // bus slave: zero wait states, okay on every access
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rdata_q   <= RDATA_RST;
      end else if (ce) begin
         wr_pend_q <= addr_phase & hwrite;
         wr_addr_q <= rd_addr;
         if (addr_phase & ~hwrite)
            rdata_q <= rd_mux;
      end
   end

   // ------------------------------------------------------------------
   // interrupt pin synchroniser: change counts when stages 2 and 3 agree
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_sync_q <= 3'h0;
         irq_lvl_q  <= 1'b0;
      end else if (ce) begin
         irq_sync_q <= {irq_sync_q[1:0], irq_pin};
         if (irq_sync_q[2] == irq_sync_q[1])
            irq_lvl_q <= irq_sync_q[2];
      end
   end

   // ------------------------------------------------------------------
   // control registers; a bus write of the return bit wins over consumption
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vector_q <= VECTOR_RST;
         irq_en_q <= 1'b0;
         ret_rq_q <= 1'b0;
      end else if (ce) begin
         if (ret_take)
            ret_rq_q <= 1'b0;
         if (wr_pend_q && wr_addr_q == CTRL_OFFSET && hwdata[0])
            ret_rq_q <= 1'b1;
         if (wr_pend_q && wr_addr_q == VECTOR_OFFSET)
            vector_q <= wd16;
         if (wr_pend_q && wr_addr_q == IRQEN_OFFSET)
            irq_en_q <= hwdata[0];
      end
   end

   // ------------------------------------------------------------------
   // entry / return sequencer; starts only with no bus write pending, then runs on through writes
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q      <= ST_RUN;
         in_service_q <= 1'b0;
         ack_q        <= 1'b0;
      end else if (ce) begin
         ack_q <= 1'b0;
         unique case (state_q)
            ST_RUN: begin
               if (irq_take)
                  state_q <= ST_PUSH_PC;
               else if (ret_take)
                  state_q <= ST_POP_SW;
            end
            ST_PUSH_PC: state_q <= ST_PUSH_SW;
            ST_PUSH_SW: state_q <= ST_ENTER;
            ST_ENTER: begin
               state_q      <= ST_RUN;
               in_service_q <= 1'b1;
               ack_q        <= 1'b1;
            end
            ST_POP_SW:  state_q <= ST_POP_PC;
            ST_POP_PC: begin
               state_q      <= ST_RUN;
               in_service_q <= 1'b0;
            end
         endcase
      end
   end

   // core registers and stack; the stack is written only by the sequencer
   // and the top-of-stack window, so handlers can edit the saved word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NUM_CORE_REGS; i++)
            core_q[i] <= REG_RST;
         for (int i = 0; i < STACK_DEPTH; i++)
            stack_q[i] <= REG_RST;
      end else if (ce) begin
         if (wr_core)
            core_q[wr_ridx] <= wd16;
         if (wr_pend_q && wr_addr_q == STKTOP_OFFSET)
            stack_q[stk_idx(sp_w)] <= wd16;
         unique case (state_q)
            ST_PUSH_PC: begin
               core_q[SP_IDX]         <= sp_dn;
               stack_q[stk_idx(sp_dn)] <= pc_w;
            end
            ST_PUSH_SW: begin
               core_q[SP_IDX]         <= sp_dn;
               stack_q[stk_idx(sp_dn)] <= sw_w;
            end
            ST_ENTER: begin
               core_q[SW_IDX] <= sw_w & ~WAKE_CLR_MASK;
               core_q[PC_IDX] <= vector_q;
            end
            ST_POP_SW: begin
               core_q[SW_IDX] <= stk_top;
               core_q[SP_IDX] <= sp_up;
            end
            ST_POP_PC: begin
               core_q[PC_IDX] <= stk_top;
               core_q[SP_IDX] <= sp_up;
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // clock gates follow the live status word one edge later
   // ------------------------------------------------------------------
   wire logic halt     = sw_w[HALT_POS];
   wire logic xtal_off = sw_w[XTAL_OFF_POS];
   wire logic gen_off  = sw_w[GEN_OFF_POS];
   wire logic sub_off  = sw_w[SUB_OFF_POS];
   // digital_osc keeps running while either the cpu or submain clock needs it
   wire logic [4:0] gate_d = {~halt, ~sub_off, ~(halt & sub_off), ~(halt & sub_off & gen_off), ~xtal_off};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_q  <= 5'h1F;
         level_q <= LVL_ACTIVE;
      end else if (ce) begin
         gate_q  <= gate_d;
         level_q <= level_of(sw_w);
      end
   end

   assign cpu_clk_en     = gate_q[4];
   assign submain_clk_en = gate_q[3];
   assign digital_osc_en = gate_q[2];
   assign dco_gen_en     = gate_q[1];
   assign crystal_osc_en = gate_q[0];
   assign sleep_level    = level_q;
   assign irq_ack        = ack_q;
   assign hrdata         = rdata_q;
   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   sequence s_entry;
      ce && state_q == ST_PUSH_PC ##1 ce && state_q == ST_PUSH_SW;
   endsequence

   sequence s_return;
      ce && state_q == ST_POP_SW ##1 ce && state_q == ST_POP_PC;
   endsequence

   AST_WAKE: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && irq_take |=> state_q == ST_PUSH_PC)
      else $error("enabled request did not start service");

   AST_PC_STACKED: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && state_q == ST_PUSH_PC |=> stack_q[stk_idx(sp_w)] == $past(pc_w) && sp_w == $past(sp_dn))
      else $error("program counter not pushed");

   AST_SW_STACKED: assert property (@(posedge hclk) disable iff (!hresetn)
      s_entry |=> state_q == ST_ENTER && stk_top == $past(sw_w))
      else $error("status word not pushed after program counter");

   AST_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && state_q == ST_ENTER |=> !sw_w[HALT_POS] && !sw_w[SUB_OFF_POS] && !sw_w[XTAL_OFF_POS]
         && sw_w[GEN_OFF_POS] == $past(sw_w[GEN_OFF_POS]) && pc_w == $past(vector_q) && irq_ack)
      else $error("entry did not clear the wake bits correctly");

   AST_RESTORE: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && state_q == ST_POP_SW |=> sw_w == $past(stk_top))
      else $error("return did not reload the stacked status word");

   AST_RETURN_DONE: assert property (@(posedge hclk) disable iff (!hresetn)
      s_return |=> state_q == ST_RUN && !in_service_q && sp_w == $past(sp_w, 2) + 16'h0004)
      else $error("return sequence did not finish");

   AST_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && $rose(halt) |=> !cpu_clk_en)
      else $error("cpu clock not gated after halt bit set");

   AST_LEVEL4: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && halt && xtal_off && gen_off && sub_off |=> sleep_level == LVL_4 && gate_q == 5'h00)
      else $error("level 4 left a clock running");

   AST_LEVEL0: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && halt && !xtal_off && !gen_off && !sub_off |=> sleep_level == LVL_0 && !cpu_clk_en
         && submain_clk_en && crystal_osc_en)
      else $error("level 0 gating wrong");

endmodule // lpm_wake_ctrl

// ===== rtl/lpm_wake_pkg.sv
// constants for the low-power wake controller: register map, status-word
// layout, sequencer states and reset values; assumes a 32-bit AHB-Lite bus
package lpm_wake_pkg;

   // ------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] CORE_REG_BASE  = 8'h00;  // r0..r15, one word each
   localparam logic [7:0] CTRL_OFFSET    = 8'h40;  // bit 0 write: return_from_interrupt
   localparam logic [7:0] STATE_OFFSET   = 8'h44;  // read-only sequencer status
   localparam logic [7:0] VECTOR_OFFSET  = 8'h48;  // handler address
   localparam logic [7:0] STKTOP_OFFSET  = 8'h4C;  // stack word at the stack pointer
   localparam logic [7:0] IRQEN_OFFSET   = 8'h50;  // bit 0: request enable

   // ------------------------------------------------------------------
   // core registers and status word
   // ------------------------------------------------------------------
   localparam int         NUM_CORE_REGS  = 16;
   localparam int         WORD_W         = 16;
   localparam logic [3:0] PC_IDX         = 4'h0;
   localparam logic [3:0] SP_IDX         = 4'h1;
   localparam logic [3:0] SW_IDX         = 4'h2;
   localparam int         IRQ_ON_POS     = 3;
   localparam int         HALT_POS       = 4;
   localparam int         XTAL_OFF_POS   = 5;
   localparam int         GEN_OFF_POS    = 6;
   localparam int         SUB_OFF_POS    = 7;
   localparam logic [15:0] WAKE_CLR_MASK = 16'h00B0;  // cpu halt, crystal off, submain off
   localparam logic [15:0] STACK_STEP    = 16'h0002;
   localparam logic [15:0] REG_RST       = 16'h0000;
   localparam logic [15:0] VECTOR_RST    = 16'h0000;
   localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

   // sleep level codes shown in the status register
   localparam logic [2:0] LVL_ACTIVE = 3'h0;
   localparam logic [2:0] LVL_0      = 3'h1;
   localparam logic [2:0] LVL_1      = 3'h2;
   localparam logic [2:0] LVL_2      = 3'h3;
   localparam logic [2:0] LVL_3      = 3'h4;
   localparam logic [2:0] LVL_4      = 3'h5;
   localparam logic [2:0] LVL_OTHER  = 3'h7;

   typedef enum logic [2:0] {ST_RUN, ST_PUSH_PC, ST_PUSH_SW, ST_ENTER, ST_POP_SW, ST_POP_PC} seq_state_t;

endpackage : lpm_wake_pkg

// ===== dv/irq_source.sv
// far-side model of the interrupt request logic feeding the wake controller
// assumes the same clock and reset as the controller
module irq_source (
   input  wire logic       hclk,      // clock
   input  wire logic       hresetn,   // async reset, active low
   input  wire logic       fire,      // one-cycle request trigger
   input  wire logic [3:0] drop_dly,  // one less than the cycles from ack to release
   input  wire logic       irq_ack,   // service entry pulse
   output logic            irq_pin    // request level
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [4:0] cnt_q;

   // level held until served, a dropped level would lose the wake
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_pin <= 1'b0;
         cnt_q   <= 5'h0;
      end else if (fire) begin
         irq_pin <= 1'b1;
      end else if (irq_ack) begin
         cnt_q <= {1'b0, drop_dly} + 5'h1;
      end else if (cnt_q != 5'h0) begin
         cnt_q <= cnt_q - 5'h1;
         if (cnt_q == 5'h1) irq_pin <= 1'b0;
      end
   end
endmodule // irq_source

// ===== dv/test_low_power_mode_wake_control.sv
// self-checking bench for the wake controller: bus tasks, level table,
// wake, stacking and return; assumes no wait states but never counts on it
module test_low_power_mode_wake_control
   import lpm_wake_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic        hclk, hresetn, ce, hsel, hwrite, fire;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, sleep_level;
   logic [3:0]  drop_dly;
   logic        hreadyout, hresp, irq_pin, irq_ack;
   logic        cpu_clk_en, submain_clk_en, digital_osc_en, dco_gen_en, crystal_osc_en;
   int          error_cnt, cmp_count;

   logic [15:0] sw_tab  [7] = '{16'h0000, 16'h0010, 16'h0050, 16'h0090, 16'h00D0, 16'h00F0, 16'h0020};
   logic [2:0]  lvl_tab [7] = '{LVL_ACTIVE, LVL_0, LVL_1, LVL_2, LVL_3, LVL_4, LVL_OTHER};
   logic [4:0]  en_tab  [7] = '{5'h1F, 5'h0F, 5'h0F, 5'h03, 5'h01, 5'h00, 5'h1E};

   lpm_wake_ctrl u_lpm_wake_ctrl (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_pin(irq_pin), .irq_ack(irq_ack),
      .cpu_clk_en(cpu_clk_en), .submain_clk_en(submain_clk_en), .digital_osc_en(digital_osc_en),
      .dco_gen_en(dco_gen_en), .crystal_osc_en(crystal_osc_en), .sleep_level(sleep_level));

   irq_source u_irq_source (.hclk(hclk), .hresetn(hresetn), .fire(fire), .drop_dly(drop_dly),
      .irq_ack(irq_ack), .irq_pin(irq_pin));

   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   // called just after a rising edge; read data lands in rd
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   function automatic logic [7:0] ra(input int n);
      return CORE_REG_BASE + 8'(4 * n);
   endfunction

   task automatic irq_in();
      fire <= 1'b1;
      @(posedge hclk);
      fire <= 1'b0;
      while (irq_ack !== 1'b1) @(posedge hclk);
   endtask

   // return request, then poll until the sequencer is back in run
   task automatic ret();
      bus(1'b1, CTRL_OFFSET, 32'h1);
      do bus(1'b0, STATE_OFFSET, 32'h0); while (rd[7] !== 1'b0 || rd[2:0] !== 3'h0);
   endtask

   task automatic gates(input logic [2:0] lvl, input logic [4:0] en);
      chk({29'h0, sleep_level}, {29'h0, lvl});
      chk({27'h0, cpu_clk_en, submain_clk_en, digital_osc_en, dco_gen_en, crystal_osc_en}, {27'h0, en});
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // clock, watchdog, tests
   // ------------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // a few hundred bus cycles expected, so this only trips on a hang
   initial begin
      repeat (5000) @(posedge hclk);
      error_cnt++;
      summarize();
   end

   initial begin
      hresetn = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; fire = 1'b0; drop_dly = 4'h0; error_cnt = 0; cmp_count = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      #1 gates(LVL_ACTIVE, 5'h1F);
      @(posedge hclk);
      for (int n = 0; n < 16; n++) rdchk(ra(n), 32'h0);
      for (int n = 3; n < 16; n++) bus(1'b1, ra(n), {16'hFFFF, 16'h1230 + 16'(n)});
      for (int n = 3; n < 16; n++) rdchk(ra(n), {16'h0, 16'h1230 + 16'(n)});
      bus(1'b1, 8'h60, 32'h5A5A_5A5A);
      rdchk(8'h60, 32'h0);
      // each encoding must reach the gates one edge after the write
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, ra(2), {16'h0, sw_tab[i]});
         @(posedge hclk);
         #1 gates(lvl_tab[i], en_tab[i]);
         @(posedge hclk);
      end
      bus(1'b1, ra(1), 32'h10);
      bus(1'b1, VECTOR_OFFSET, 32'h1234);
      bus(1'b1, ra(0), 32'hBEEF);
      bus(1'b1, ra(2), 32'hD8);
      // request while masked must not be taken
      fire <= 1'b1;
      @(posedge hclk);
      fire <= 1'b0;
      repeat (20) @(posedge hclk);
      bus(1'b0, STATE_OFFSET, 32'h0);
      chk({31'h0, rd[7]}, 32'h0);
      rdchk(ra(0), 32'hBEEF);
      bus(1'b1, IRQEN_OFFSET, 32'h1);
      while (irq_ack !== 1'b1) @(posedge hclk);
      repeat (2) @(posedge hclk);
      rdchk(ra(0), 32'h1234);
      rdchk(ra(2), 32'h48);
      rdchk(ra(1), 32'hC);
      rdchk(STKTOP_OFFSET, 32'hD8);
      bus(1'b1, ra(1), 32'hE);
      rdchk(STKTOP_OFFSET, 32'hBEEF);
      bus(1'b1, ra(1), 32'hC);
      gates(LVL_OTHER, 5'h1F);
      ret();
      rdchk(ra(2), 32'hD8);
      rdchk(ra(0), 32'hBEEF);
      rdchk(ra(1), 32'h10);
      gates(LVL_3, 5'h01);
      // slow partner release, stacked word rewritten by the handler
      drop_dly <= 4'h9;
      irq_in();
      bus(1'b1, STKTOP_OFFSET, 32'h8);
      // let the slow request level die out first, else the return re-enters at once
      repeat (16) @(posedge hclk);
      ret();
      rdchk(ra(2), 32'h8);
      gates(LVL_ACTIVE, 5'h1F);
      summarize();
   end
endmodule // test_low_power_mode_wake_control
